// >>> design/bppc_pkg.sv
// Package with constants and types for the battery pack protection control block
// Summary of operation
// - Fault delays take 0..1023 counts and unit
// - After overcurrent trip, pulse release detection current
// - Release pulse width programmable 1 to 16 ms
// - No current: normal, idle, doze, sleep by timers
// - Any current returns to normal mode
// - Any override starts the guard timer
// - Each valid slave byte restarts guard timer
// - Guard expiry turns FETs off until command
// - Cell select is one of six masks
// - Invalid cell mask keeps all FETs off
// - Overvoltage on selected cell at power-up halts
// - All cells outside limits stops charge/discharge balance (not end-of-charge), hysteresis
// - Spread above limit sets cell fail flag
// - Cell fail flag starts open-wire detection
// - Balance stops when temperature out of bounds
// - Balance alternates on and off times
// - FET temp option: second input only kills FETs
// - Options set pack shutdown; disable open-wire scan
// - Lockout power-down option powers device down
// - Cascade lower device drops sensing and FET drive
// - Charge or discharge balance needs that current
// - End-of-charge balance with 117 mV window
package bppc_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;    // System clock rate
  localparam int unsigned US_CYC       = CLK_HZ / 1_000_000; // Cycles per microsecond
  localparam int unsigned MS_CYC       = CLK_HZ / 1_000; // Cycles per millisecond
  localparam int unsigned DLY_MAX      = 1023;          // Largest delay count
  localparam int unsigned PULSE_MS_MIN = 1;             // Shortest release pulse
  localparam int unsigned PULSE_MS_MAX = 16;            // Longest release pulse
  localparam int unsigned PULSE_GAP_MS = 16;            // Gap between release pulses
  localparam int unsigned EOC_HYST_MV  = 117;           // End-of-charge release window
  localparam logic [7:0]  MASK_C3      = 8'h83;         // Three cells
  localparam logic [7:0]  MASK_C4      = 8'hc3;         // Four cells
  localparam logic [7:0]  MASK_C5      = 8'hc7;         // Five cells
  localparam logic [7:0]  MASK_C6      = 8'he7;         // Six cells
  localparam logic [7:0]  MASK_C7      = 8'hef;         // Seven cells
  localparam logic [7:0]  MASK_C8      = 8'hff;         // Eight cells
  localparam logic [1:0]  UNIT_US      = 2'h0;          // Delay unit codes
  localparam logic [1:0]  UNIT_MS      = 2'h1;
  localparam logic [1:0]  UNIT_S       = 2'h2;
  localparam logic [1:0]  UNIT_MIN     = 2'h3;
  localparam logic [3:0]  BAL_RST      = 4'h0;          // Balance masks after reset
  // Power modes
  typedef enum logic [1:0] {BPPC_NORMAL, BPPC_IDLE, BPPC_DOZE, BPPC_SLEEP} bppc_mode_t;
endpackage : bppc_pkg

// >>> design/bppc_top.sv
// Battery pack protection control: timers, guard, balance and option logic
`timescale 1ns/100ps
module bppc_top #(
  parameter int unsigned SEC_CYC   = 20_000_000,   // Cycles per second
  parameter int unsigned GUARD_CYC = 20_000_000,   // Guard timeout in cycles
  parameter int unsigned MODE_TICK = 20_000_000    // Cycles per mode timer count
) (
  // Clocks and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        clk_link_i,       // Slave serial link clock
  // Link side events
  input  wire logic        byte_ok_i,        // Valid slave byte, link clock
  // Overcurrent timing
  input  wire logic        oc_raw_i,         // Raw overcurrent comparator
  input  wire logic [9:0]  oc_delay_i,       // Delay count 0..1023
  input  wire logic [1:0]  oc_unit_i,        // Delay unit
  input  wire logic [3:0]  pulse_ms_i,       // Release pulse width minus one
  input  wire logic        released_i,       // Load or charger released
  // Power mode
  input  wire logic        current_i,        // Any pack current, pin
  input  wire logic [7:0]  idle_time_i,      // Normal to idle and idle to doze
  input  wire logic [7:0]  sleep_time_i,     // Doze to sleep
  // Override and cells
  input  wire logic        override_i,       // Any override asserted
  input  wire logic [7:0]  cell_sel_i,       // Cell-select mask
  input  wire logic        pwrup_ov_i,       // Selected cell overvoltage at power-up
  // Balance conditions
  input  wire logic        all_out_lim_i,    // Every cell outside limits
  input  wire logic        all_in_hyst_i,    // Every cell inside limits by hysteresis
  input  wire logic        spread_over_i,    // Highest minus lowest above spread limit
  input  wire logic        temp_bad_i,       // Balance temperature out of bounds
  input  wire logic        second_temp_ot_i, // Over-temperature on second input
  input  wire logic        chg_cur_i,        // Charge current detected
  input  wire logic        dsg_cur_i,        // Discharge current detected
  input  wire logic        eoc_reach_i,      // Any cell at end-of-charge
  input  wire logic        eoc_hold_i,       // Any cell above threshold minus window
  input  wire logic [7:0]  cell_above_i,     // Cells above lowest plus start offset
  input  wire logic [7:0]  balance_on_time_i,
  input  wire logic [7:0]  balance_off_time_i,
  // Options
  input  wire logic        opt_fet_temp_i,
  input  wire logic        opt_cf_psd_i,
  input  wire logic        opt_ow_psd_i,
  input  wire logic        opt_uv_pd_i,
  input  wire logic        opt_ow_dis_i,
  input  wire logic        opt_cascade_i,
  input  wire logic        pos_is_reg_i,     // Position pin tied to regulator output
  input  wire logic        open_wire_i,      // Open wire found
  input  wire logic        undervoltage_lockout_i,
  input  wire logic        bal_chg_en_i,
  input  wire logic        bal_dsg_en_i,
  input  wire logic        bal_eoc_en_i,
  // Outputs
  output logic             fet_on_o,
  output logic             det_pulse_o,
  output logic [1:0]       mode_o,
  output logic             cell_fail_flag_o,
  output logic             ow_start_o,
  output logic             pack_shutdown_o,
  output logic             power_down_o,
  output logic [7:0]       balance_o,
  output logic             sense_en_o,
  output logic             addr_alt_o,
  output logic             pwrup_done_o,
  output logic             guard_trip_o
);

  // Link domain: toggle per valid byte
  logic tgl_ff;
  always_ff @(posedge clk_link_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgl_ff <= 1'b0;
    end else if (byte_ok_i) begin
      tgl_ff <= ~tgl_ff;
    end
  end

  // System state, apart from the registered outputs, in one struct
  typedef struct packed {
    logic [2:0]  tsync;      // Toggle synchroniser plus history
    logic [1:0]  cur_s;      // Current pin synchroniser
    logic [1:0]  oc_s;       // Overcurrent pin synchroniser
    logic [9:0]  dly_cnt;    // Delay count
    logic [31:0] unit_cnt;   // Unit prescaler
    logic        tripped;    // FETs off for overcurrent
    logic [31:0] pulse_cnt;  // Release pulse timer
    logic        pulse;
    bppc_pkg::bppc_mode_t mode;
    logic [31:0] mtick;
    logic [7:0]  mcnt;
    logic        guard_run;
    logic [31:0] guard_cnt;
    logic        guard_trip;
    logic        pwr_ok;
    logic        pwr_chk;
    logic        bal_stop;
    logic        eoc_act;
    logic        bal_phase;
    logic [7:0]  bal_cnt;
    logic        cf;
    logic        ows;
    logic        pack_shutdown;
    logic        pd;
  } bppc_state_t;

  bppc_state_t s_ff;
  bppc_state_t nxt_s;

  // Valid cell mask decode
  function automatic logic bppc_mask_ok(input logic [7:0] m);
    return (m == bppc_pkg::MASK_C3) || (m == bppc_pkg::MASK_C4) ||
           (m == bppc_pkg::MASK_C5) || (m == bppc_pkg::MASK_C6) ||
           (m == bppc_pkg::MASK_C7) || (m == bppc_pkg::MASK_C8);
  endfunction

  // Unit length in cycles
  function automatic logic [31:0] bppc_unit(input logic [1:0] u);
    case (u)
      bppc_pkg::UNIT_US: return 32'(bppc_pkg::US_CYC);
      bppc_pkg::UNIT_MS: return 32'(bppc_pkg::MS_CYC);
      bppc_pkg::UNIT_S:  return 32'(SEC_CYC);
      default:           return 32'(SEC_CYC * 60);
    endcase
  endfunction

  logic byte_evt;     // One-cycle valid byte pulse
  logic lower_dev;    // Cascade lower device
  logic bal_allow;    // Balance allowed now
  assign byte_evt  = s_ff.tsync[2] ^ s_ff.tsync[1];
  assign lower_dev = opt_cascade_i & pos_is_reg_i;

  // Balance gating by current and temperature
  always_comb begin
    bal_allow = 1'b0;
    if (bal_eoc_en_i) begin
      bal_allow = s_ff.eoc_act;
    end else if (bal_chg_en_i && chg_cur_i) begin
      bal_allow = !s_ff.bal_stop;
    end else if (bal_dsg_en_i && dsg_cur_i) begin
      bal_allow = !s_ff.bal_stop;
    end
    // Second input OT spares balance only with FET temp option
    if (temp_bad_i || (second_temp_ot_i && !opt_fet_temp_i)) begin
      bal_allow = 1'b0;
    end
  end

  // Next state
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.tsync = {s_ff.tsync[1:0], tgl_ff};
    nxt_s.cur_s = {s_ff.cur_s[0], current_i};
    nxt_s.oc_s  = {s_ff.oc_s[0], oc_raw_i};
    // Overcurrent delay: count units while condition stands
    if (!s_ff.oc_s[1] || s_ff.tripped) begin
      nxt_s.dly_cnt  = 10'h0;
      nxt_s.unit_cnt = 32'h0;
    end else if (s_ff.dly_cnt >= oc_delay_i) begin
      nxt_s.tripped = 1'b1;
    end else if (s_ff.unit_cnt >= bppc_unit(oc_unit_i) - 32'h1) begin
      nxt_s.unit_cnt = 32'h0;
      nxt_s.dly_cnt  = s_ff.dly_cnt + 10'h1;
    end else begin
      nxt_s.unit_cnt = s_ff.unit_cnt + 32'h1;
    end
    // Release pulses while tripped; width (pulse_ms+1) ms
    if (!s_ff.tripped) begin
      nxt_s.pulse     = 1'b0;
      nxt_s.pulse_cnt = 32'h0;
    end else if (released_i && !s_ff.pulse) begin
      nxt_s.tripped   = 1'b0;
    end else if (s_ff.pulse && s_ff.pulse_cnt >=
                 32'(pulse_ms_i) * 32'(bppc_pkg::MS_CYC) + 32'(bppc_pkg::MS_CYC) - 32'h1) begin
      nxt_s.pulse     = 1'b0;
      nxt_s.pulse_cnt = 32'h0;
    end else if (!s_ff.pulse && s_ff.pulse_cnt >=
                 32'(bppc_pkg::PULSE_GAP_MS * bppc_pkg::MS_CYC) - 32'h1) begin
      nxt_s.pulse     = 1'b1;
      nxt_s.pulse_cnt = 32'h0;
    end else begin
      nxt_s.pulse_cnt = s_ff.pulse_cnt + 32'h1;
    end
    // Power mode timer chain
    if (s_ff.cur_s[1]) begin
      nxt_s.mode  = bppc_pkg::BPPC_NORMAL;
      nxt_s.mtick = 32'h0;
      nxt_s.mcnt  = 8'h0;
    end else if (s_ff.mode != bppc_pkg::BPPC_SLEEP) begin
      if (s_ff.mtick >= 32'(MODE_TICK) - 32'h1) begin
        nxt_s.mtick = 32'h0;
        nxt_s.mcnt  = s_ff.mcnt + 8'h1;
      end else begin
        nxt_s.mtick = s_ff.mtick + 32'h1;
      end
      case (s_ff.mode)
        bppc_pkg::BPPC_NORMAL: begin
          if (s_ff.mcnt >= idle_time_i) begin
            nxt_s.mode = bppc_pkg::BPPC_IDLE;
            nxt_s.mcnt = 8'h0;
            nxt_s.mtick = 32'h0;
          end
        end
        bppc_pkg::BPPC_IDLE: begin
          if (s_ff.mcnt >= idle_time_i) begin
            nxt_s.mode = bppc_pkg::BPPC_DOZE;
            nxt_s.mcnt = 8'h0;
            nxt_s.mtick = 32'h0;
          end
        end
        bppc_pkg::BPPC_DOZE: begin
          if (s_ff.mcnt >= sleep_time_i) begin
            nxt_s.mode = bppc_pkg::BPPC_SLEEP;
          end
        end
        default: begin
          nxt_s.mode = bppc_pkg::BPPC_SLEEP;
        end
      endcase
    end
    // Override guard timer
    if (byte_evt) begin
      nxt_s.guard_cnt  = 32'h0;
      nxt_s.guard_trip = 1'b0;
      nxt_s.guard_run  = override_i;
    end else if (override_i && !s_ff.guard_run && !s_ff.guard_trip) begin
      nxt_s.guard_run = 1'b1;
      nxt_s.guard_cnt = 32'h0;
    end else if (s_ff.guard_run && !override_i) begin
      // Overrides dropped: nothing left to guard, so stop without tripping
      nxt_s.guard_run = 1'b0;
    end else if (s_ff.guard_run) begin
      if (s_ff.guard_cnt >= 32'(GUARD_CYC) - 32'h1) begin
        nxt_s.guard_trip = 1'b1;
        nxt_s.guard_run  = 1'b0;
      end else begin
        nxt_s.guard_cnt = s_ff.guard_cnt + 32'h1;
      end
    end
    // Power-up check one cycle after release
    if (!s_ff.pwr_chk) begin
      nxt_s.pwr_chk = 1'b1;
      nxt_s.pwr_ok  = !pwrup_ov_i;
    end
    // Limit stop with hysteresis
    if (all_out_lim_i) begin
      nxt_s.bal_stop = 1'b1;
    end else if (all_in_hyst_i) begin
      nxt_s.bal_stop = 1'b0;
    end
    // End-of-charge window
    if (!bal_eoc_en_i) begin
      nxt_s.eoc_act = 1'b0;
    end else if (eoc_reach_i) begin
      nxt_s.eoc_act = 1'b1;
    end else if (!eoc_hold_i) begin
      nxt_s.eoc_act = 1'b0;
    end
    // On/off duty timer
    if (!bal_allow) begin
      nxt_s.bal_phase = 1'b1;
      nxt_s.bal_cnt   = 8'h0;
    end else if (s_ff.bal_cnt >= (s_ff.bal_phase ? balance_on_time_i : balance_off_time_i)) begin
      nxt_s.bal_phase = ~s_ff.bal_phase;
      nxt_s.bal_cnt   = 8'h0;
    end else begin
      nxt_s.bal_cnt = s_ff.bal_cnt + 8'h1;
    end
    // Cell fail flag and open-wire start
    nxt_s.ows = 1'b0;
    if (spread_over_i && !s_ff.cf) begin
      nxt_s.cf  = 1'b1;
      nxt_s.ows = !opt_ow_dis_i;
    end else if (!spread_over_i) begin
      nxt_s.cf  = 1'b0;
    end
    if ((spread_over_i && opt_cf_psd_i) || (open_wire_i && opt_ow_psd_i && !opt_ow_dis_i)) begin
      nxt_s.pack_shutdown = 1'b1;
    end
    if (undervoltage_lockout_i && opt_uv_pd_i) begin
      nxt_s.pd = 1'b1;
    end
  end

  // Register the state
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Registered outputs
  logic [7:0] balance_ff;
  logic       fet_ff;
  logic       sense_ff;
  logic       addr_ff;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      balance_ff <= 8'h0;
      fet_ff     <= 1'b0;
      sense_ff   <= 1'b0;
      addr_ff    <= 1'b0;
    end else begin
      balance_ff <= (bal_allow && s_ff.bal_phase) ? (cell_above_i & cell_sel_i) : 8'h0;
      fet_ff     <= s_ff.pwr_ok && bppc_mask_ok(cell_sel_i) && !s_ff.tripped &&
                    !s_ff.guard_trip && !lower_dev && !second_temp_ot_i;
      sense_ff   <= !lower_dev;
      addr_ff    <= opt_cascade_i & pos_is_reg_i;
    end
  end

  assign fet_on_o         = fet_ff;
  assign det_pulse_o      = s_ff.pulse;
  assign mode_o           = s_ff.mode;
  assign cell_fail_flag_o = s_ff.cf;
  assign ow_start_o       = s_ff.ows;
  assign pack_shutdown_o  = s_ff.pack_shutdown;
  assign power_down_o     = s_ff.pd;
  assign balance_o        = balance_ff;
  assign sense_en_o       = sense_ff;
  assign addr_alt_o       = addr_ff;
  assign pwrup_done_o     = s_ff.pwr_ok;
  assign guard_trip_o     = s_ff.guard_trip;

  // Checks; outputs are registered, so most effects show one edge later
  chk_bad_mask_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !bppc_mask_ok($past(cell_sel_i)) |-> !fet_on_o) else $error("fet on with bad mask");
  chk_guard_fet_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_ff.guard_trip |=> !fet_on_o) else $error("fet on after guard trip");
  chk_cur_to_normal: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_ff.cur_s[1] |=> s_ff.mode == bppc_pkg::BPPC_NORMAL) else $error("no return to normal");
  chk_byte_restart: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    byte_evt |=> s_ff.guard_cnt == 32'h0 && !s_ff.guard_trip) else $error("guard not restarted");
  chk_override_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    override_i && !s_ff.guard_trip |=> s_ff.guard_run || s_ff.guard_trip) else $error("no guard");
  chk_spread_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    spread_over_i |=> cell_fail_flag_o) else $error("cell fail not set");
  // Scan start rides on the first cycle of the flag
  chk_ow_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(cell_fail_flag_o) && !$past(opt_ow_dis_i) |-> ow_start_o) else $error("no scan start");
  chk_temp_bal_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    temp_bad_i |=> balance_o == 8'h0) else $error("balance in bad temperature");
  chk_uv_pd: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    undervoltage_lockout_i && opt_uv_pd_i |=> power_down_o) else $error("no power down");
  chk_lower_dev: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    lower_dev |=> !fet_on_o && !sense_en_o) else $error("lower device drives");
  // Dropping every override must not run the guard into a trip
  chk_guard_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !override_i && !s_ff.guard_trip |=> !s_ff.guard_trip) else $error("stray guard trip");
  // Charge/discharge balance stops as soon as every cell leaves the limits
  chk_limit_stop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    all_out_lim_i |=> s_ff.bal_stop) else $error("limits did not stop balance");
  // End-of-charge balance latches on the first cell at the threshold
  chk_eoc_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    bal_eoc_en_i && eoc_reach_i |=> s_ff.eoc_act) else $error("eoc balance not started");
  // A failed power-up check holds every FET off
  chk_pwrup_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !s_ff.pwr_ok |=> !fet_on_o) else $error("fet on before power-up");

  // Covers for the main scenarios
  cov_trip: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(s_ff.tripped));
  cov_sleep: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_ff.mode == bppc_pkg::BPPC_SLEEP);
  cov_guard: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) $rose(s_ff.guard_trip));
  cov_bal: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) balance_o != 8'h0);
  cov_eoc: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(s_ff.eoc_act));

endmodule : bppc_top

// >>> dv/bppc_mcu_model.sv
// Behavioural microcontroller on the slave link: valid byte strobes
`timescale 1ns/100ps
module bppc_mcu_model #(
  parameter int unsigned GAP_FAST = 40,   // Link cycles between bytes, prompt
  parameter int unsigned GAP_SLOW = 400   // Link cycles between bytes, slow
) (
  // Link clock and reset
  input  wire logic clk_link_i,
  input  wire logic nrst_i,
  // Bench control
  input  wire logic talk_i,               // Keep sending bytes
  input  wire logic slow_i,               // Use the long spacing
  // Byte strobe to the block
  output logic      byte_ok_o             // One link cycle per valid byte
);
  int unsigned cnt_ff;                    // Link cycles since last byte
  // Slow spacing still sits well inside the guard time, so overrides live
  always_ff @(posedge clk_link_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff    <= 0;
      byte_ok_o <= 1'b0;
    end else if (talk_i && cnt_ff >= (slow_i ? GAP_SLOW : GAP_FAST)) begin
      cnt_ff    <= 0;
      byte_ok_o <= 1'b1;
    end else begin
      cnt_ff    <= cnt_ff + 1;
      byte_ok_o <= 1'b0;
    end
  end
endmodule // bppc_mcu_model

// >>> dv/bppc_top_tb_top.sv
// Self-checking bench for the pack protection control block
`timescale 1ns/100ps
module bppc_top_tb_top;
  localparam int unsigned SEC = 100;      // Shortened second
  localparam int unsigned LIMIT = 8000;   // Cycle ceiling for the run
  // Design inputs, named as the ports
  logic clk_sys_i = 0, clk_link_i = 0, nrst_i = 0, byte_ok_i, talk = 0, slow = 0;
  logic oc_raw_i = 0, released_i = 0, current_i = 1, override_i = 0, pwrup_ov_i = 0;
  logic all_out_lim_i = 0, all_in_hyst_i = 1, spread_over_i = 0, temp_bad_i = 0;
  logic second_temp_ot_i = 0, chg_cur_i = 0, dsg_cur_i = 0, eoc_reach_i = 0, eoc_hold_i = 0;
  logic opt_fet_temp_i = 0, opt_cf_psd_i = 0, opt_ow_psd_i = 0, opt_uv_pd_i = 0;
  logic opt_ow_dis_i = 0, opt_cascade_i = 0, pos_is_reg_i = 0, open_wire_i = 0;
  logic undervoltage_lockout_i = 0, bal_chg_en_i = 0, bal_dsg_en_i = 0, bal_eoc_en_i = 0;
  logic [9:0] oc_delay_i = '0;
  logic [1:0] oc_unit_i = '0;
  logic [3:0] pulse_ms_i = '0;
  logic [7:0] idle_time_i = 8'h02, sleep_time_i = 8'h03, cell_sel_i = 8'hff;
  logic [7:0] cell_above_i = 8'h01, balance_on_time_i = 8'h03, balance_off_time_i = 8'h03;
  // Design outputs
  logic fet_on_o, det_pulse_o, cell_fail_flag_o, ow_start_o, pack_shutdown_o, power_down_o;
  logic sense_en_o, addr_alt_o, pwrup_done_o, guard_trip_o;
  logic [1:0] mode_o;
  logic [7:0] balance_o;
  // Bench bookkeeping
  int err_count = 0, n_compared = 0, cyc_cnt = 0, seed = 32'ha8bf, n;
  logic seen;
  // The six legal cell masks, fewest cells first
  logic [7:0] legal_mask [6] = '{bppc_pkg::MASK_C3, bppc_pkg::MASK_C4, bppc_pkg::MASK_C5,
                                 bppc_pkg::MASK_C6, bppc_pkg::MASK_C7, bppc_pkg::MASK_C8};

  bppc_top #(.SEC_CYC(SEC), .GUARD_CYC(200), .MODE_TICK(10)) bppc_top_i (.*);
  bppc_mcu_model bppc_mcu_model_i (.clk_link_i(clk_link_i), .nrst_i(nrst_i), .talk_i(talk),
                                   .slow_i(slow), .byte_ok_o(byte_ok_i));

  // Clocks: unrelated periods, so link edges wander against system edges
  always #25 clk_sys_i = ~clk_sys_i;
  always #6 clk_link_i = ~clk_link_i;

  // Hang guard: a run that overstays counts as a mismatch
  always @(posedge clk_sys_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  // Inputs move a fixed 2 ns after the edge; outputs are settled then
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #2;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Only six cell masks are legal
  function automatic logic mask_ok(input logic [7:0] m);
    return m inside {bppc_pkg::MASK_C3, bppc_pkg::MASK_C4, bppc_pkg::MASK_C5,
                     bppc_pkg::MASK_C6, bppc_pkg::MASK_C7, bppc_pkg::MASK_C8};
  endfunction

  // Cycles per delay unit, with the shortened second
  function automatic int unit_cyc(input logic [1:0] u);
    case (u)
      bppc_pkg::UNIT_US: return bppc_pkg::US_CYC;
      bppc_pkg::UNIT_MS: return bppc_pkg::MS_CYC;
      bppc_pkg::UNIT_S:  return SEC;
      default:           return SEC * 60;
    endcase
  endfunction

  task automatic do_rst(input logic ov);
    nrst_i = 0;
    pwrup_ov_i = ov;
    tick(4);
    chk("fet in reset", 0, fet_on_o);
    nrst_i = 1;
    tick(4);
    chk("powerup done", !ov, pwrup_done_o);
    chk("fet after powerup", !ov, fet_on_o);
  endtask

  // Watch balance outputs over two full on/off periods
  task automatic bal_watch(input string nm, input logic e);
    logic son, soff;
    son = 0;
    soff = 0;
    cell_above_i = 8'($random(seed)) | 8'h01;
    tick(4);
    repeat (40) begin
      tick(1);
      if (balance_o !== 8'h00) begin
        son = 1;
        chk(nm, cell_sel_i & cell_above_i, balance_o);
      end else soff = 1;
    end
    chk(nm, e, son);
    if (e) chk(nm, 1, soff);
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    pulse_ms_i = 4'($random(seed));
    do_rst(0);
    // Legal masks let the FET on, any other keeps it off
    for (int i = 0; i < 14; i++) begin
      cell_sel_i = (i < 6) ? legal_mask[i] : 8'($random(seed));
      tick(4);
      chk("fet vs mask", mask_ok(cell_sel_i), fet_on_o);
    end
    cell_sel_i = bppc_pkg::MASK_C8;
    tick(4);
    $display("test masks done");
    // Overcurrent delay in four randomly drawn units, then release clears the trip
    repeat (4) begin
      oc_unit_i = 2'($random(seed));
      oc_delay_i = 10'($random(seed) & 3);
      // Long units only with a zero count, so the run stays short
      if (oc_unit_i inside {bppc_pkg::UNIT_MS, bppc_pkg::UNIT_MIN}) oc_delay_i = 10'h0;
      // Two sync edges, the count of units, then one edge to trip
      n = oc_delay_i * unit_cyc(oc_unit_i);
      oc_raw_i = 1;
      tick(n + 3);
      chk("fet before trip", 1, fet_on_o);
      tick(1);
      chk("fet after trip", 0, fet_on_o);
      chk("pulse in gap", 0, det_pulse_o);
      oc_raw_i = 0;
      released_i = 1;
      tick(5);
      chk("fet on release", 1, fet_on_o);
      released_i = 0;
      tick(2);
    end
    $display("test overcurrent done");
    // Mode chain with idle 2 and sleep 3 ticks of 10 cycles
    current_i = 0;
    tick(15);
    chk("mode", 16'(bppc_pkg::BPPC_NORMAL), mode_o);
    tick(17);
    chk("mode", 16'(bppc_pkg::BPPC_IDLE), mode_o);
    tick(20);
    chk("mode", 16'(bppc_pkg::BPPC_DOZE), mode_o);
    tick(33);
    chk("mode", 16'(bppc_pkg::BPPC_SLEEP), mode_o);
    current_i = 1;
    tick(6);
    chk("mode", 16'(bppc_pkg::BPPC_NORMAL), mode_o);
    $display("test modes done");
    // Balance conditions
    balance_on_time_i = 8'($random(seed) & 7);
    balance_off_time_i = 8'($random(seed) & 7);
    bal_chg_en_i = 1;
    chg_cur_i = 1;
    bal_watch("bal charge", 1);
    temp_bad_i = 1;
    bal_watch("bal temp", 0);
    temp_bad_i = 0;
    opt_fet_temp_i = 1;
    second_temp_ot_i = 1;
    bal_watch("bal fet temp", 1);
    chk("fet on fet temp", 0, fet_on_o);
    second_temp_ot_i = 0;
    chg_cur_i = 0;
    dsg_cur_i = 1;
    bal_watch("bal wrong current", 0);
    bal_chg_en_i = 0;
    bal_dsg_en_i = 1;
    bal_watch("bal discharge", 1);
    all_in_hyst_i = 0;
    all_out_lim_i = 1;
    bal_watch("bal out limits", 0);
    all_out_lim_i = 0;
    bal_watch("bal hysteresis", 0);
    all_in_hyst_i = 1;
    bal_watch("bal resume", 1);
    bal_dsg_en_i = 0;
    dsg_cur_i = 0;
    bal_eoc_en_i = 1;
    eoc_reach_i = 1;
    bal_watch("bal eoc start", 1);
    eoc_reach_i = 0;
    eoc_hold_i = 1;
    bal_watch("bal eoc hold", 1);
    eoc_hold_i = 0;
    bal_watch("bal eoc end", 0);
    $display("test balance done");
    // Cascade position decides sensing, FET drive and address
    opt_cascade_i = 1;
    for (int p = 1; p >= 0; p--) begin
      pos_is_reg_i = p[0];
      tick(5);
      chk("sense en", !p[0], sense_en_o);
      chk("fet cascade", !p[0], fet_on_o);
      chk("addr alt", p[0], addr_alt_o);
    end
    opt_cascade_i = 0;
    // Guard timer kept alive by slow bytes, then starved
    override_i = 1;
    talk = 1;
    slow = 1;
    tick(600);
    chk("guard alive", 0, guard_trip_o);
    talk = 0;
    tick(300);
    chk("guard trip", 1, guard_trip_o);
    chk("fet on guard trip", 0, fet_on_o);
    talk = 1;
    slow = 0;
    tick(20);
    chk("guard cleared", 0, guard_trip_o);
    override_i = 0;
    talk = 0;
    tick(250);
    chk("guard idle", 0, guard_trip_o);
    $display("test guard done");
    // Cell fail flag with option combinations {psd, scan off}
    for (int k = 0; k < 3; k++) begin
      opt_cf_psd_i = (k == 2);
      opt_ow_dis_i = (k == 1);
      spread_over_i = 1;
      seen = 0;
      repeat (6) begin
        tick(1);
        seen |= ow_start_o;
      end
      chk("cell fail", 1, cell_fail_flag_o);
      chk("open wire start", k != 1, seen);
      chk("pack shutdown", k == 2, pack_shutdown_o);
      spread_over_i = 0;
      tick(4);
      chk("cell fail clear", 0, cell_fail_flag_o);
    end
    chk("shutdown sticky", 1, pack_shutdown_o);
    // Mid-run resets: overvoltage at power-up halts, then clean start
    do_rst(1);
    do_rst(0);
    open_wire_i = 1;
    undervoltage_lockout_i = 1;
    tick(4);
    chk("psd no option", 0, pack_shutdown_o);
    chk("pd no option", 0, power_down_o);
    open_wire_i = 0;
    undervoltage_lockout_i = 0;
    opt_ow_psd_i = 1;
    opt_uv_pd_i = 1;
    tick(2);
    open_wire_i = 1;
    undervoltage_lockout_i = 1;
    tick(4);
    chk("psd open wire", 1, pack_shutdown_o);
    chk("power down", 1, power_down_o);
    $display("test options done");
    print_verdict();
  end
endmodule // bppc_top_tb_top
